// ==== common/mde_pkg.sv ====
/*
  Shared constants and types of the instruction decode and execute block.
  Assumes a single 200 MHz core clock that also acts as the oscillator.
*/
package mde_pkg;

  // ***********************************************************
  // widths and field positions
  // ***********************************************************
  localparam int INSTR_W     = 14;
  localparam int DATA_W      = 8;
  localparam int FADDR_W     = 7;
  localparam int PC_W        = 13;
  localparam int LIT_JUMP_W  = 11;
  localparam int PAGE_W      = PC_W - LIT_JUMP_W;
  localparam int STACK_DEPTH = 8;
  localparam int SP_W        = 3;
  localparam int DEST_BIT    = 7;
  localparam int BSEL_LSB    = 7;
  localparam int CLASS_LSB   = 12;
  localparam int BOP_LSB     = 8;
  localparam int JSEL_BIT    = 11;

  // ***********************************************************
  // timing: oscillator periods per instruction cycle
  // ***********************************************************
  localparam real CLK_PERIOD_NS  = 5.0;
  localparam int  PHASES_PER_CYC = 4;

  // ***********************************************************
  // instruction classes and opcodes
  // ***********************************************************
  localparam logic [1:0] CLS_BYTE = 2'h0;
  localparam logic [1:0] CLS_BIT  = 2'h1;
  localparam logic [1:0] CLS_JUMP = 2'h2;
  localparam logic [1:0] CLS_LIT  = 2'h3;
  localparam logic [3:0] BOP_MISC = 4'h0;
  localparam logic [3:0] BOP_CLR  = 4'h1;
  localparam logic [3:0] BOP_SUB  = 4'h2;
  localparam logic [3:0] BOP_DEC  = 4'h3;
  localparam logic [3:0] BOP_IOR  = 4'h4;
  localparam logic [3:0] BOP_AND  = 4'h5;
  localparam logic [3:0] BOP_XOR  = 4'h6;
  localparam logic [3:0] BOP_ADD  = 4'h7;
  localparam logic [3:0] BOP_MOV  = 4'h8;
  localparam logic [3:0] BOP_COM  = 4'h9;
  localparam logic [3:0] BOP_INC  = 4'hA;
  localparam logic [3:0] BOP_DECSZ = 4'hB;
  localparam logic [3:0] BOP_RR   = 4'hC;
  localparam logic [3:0] BOP_RL   = 4'hD;
  localparam logic [3:0] BOP_SWAP = 4'hE;
  localparam logic [3:0] BOP_INCSZ = 4'hF;
  localparam logic [7:0] MISC_RETURN  = 8'h08;
  localparam logic [7:0] MISC_RETFIE  = 8'h09;
  localparam logic [7:0] MISC_SLEEP   = 8'h63;
  localparam logic [7:0] MISC_CLRWDT  = 8'h64;

  // ***********************************************************
  // reset values and fixed addresses
  // ***********************************************************
  localparam logic [PC_W-1:0]    PC_RESET   = 13'h0000;
  localparam logic [FADDR_W-1:0] PORT_ADDR  = 7'h05;
  localparam logic [DATA_W-1:0]  W_RESET    = 8'h00;
  localparam logic [SP_W-1:0]    SP_RESET   = 3'h0;

  typedef enum logic [3:0] {
    PH_Q1 = 4'b0001,
    PH_Q2 = 4'b0010,
    PH_Q3 = 4'b0100,
    PH_Q4 = 4'b1000
  } mde_phase_t;

  typedef struct packed {
    logic c;
    logic dc;
    logic z;
  } mde_status_t;

  typedef struct packed {
    logic instr_done;
    logic sleep_req;
    logic wdt_clear;
    logic int_return;
  } mde_ctrl_t;

  typedef struct packed {
    logic [DATA_W-1:0] result;
    mde_status_t       flags;
    mde_status_t       upd;
    logic              skip;
  } mde_alu_out_t;

endpackage

// ==== design/mde_alu.sv ====
/*
  Combinational arithmetic and logic unit of the decode and execute block.
  Assumes the instruction word, working value, operand and carry are stable.
*/
`timescale 1ns/1ps
`default_nettype none

module mde_alu
  import mde_pkg::*;
(
  // operands
  input  wire logic [INSTR_W-1:0] instr,
  input  wire logic [DATA_W-1:0]  w_val,
  input  wire logic [DATA_W-1:0]  f_val,
  input  wire logic               c_in,
  // result
  output mde_alu_out_t            alu_out
);

  // ***********************************************************
  // adder shared by all add, subtract, increment, decrement ops
  // ***********************************************************
  function automatic logic [9:0] add8(input logic [7:0] a, input logic [7:0] b,
                                      input logic cin);
    logic [4:0] lo;
    logic [8:0] full;
    lo   = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
    return {full[8], lo[4], full[7:0]};
  endfunction

  // field selection
  wire logic [1:0]        cls  = instr[CLASS_LSB+1:CLASS_LSB];
  wire logic [3:0]        bop  = instr[BOP_LSB+3:BOP_LSB];
  wire logic [2:0]        bsel = instr[BSEL_LSB+2:BSEL_LSB];
  wire logic [DATA_W-1:0] lit  = instr[DATA_W-1:0];
  wire logic [DATA_W-1:0] bmask = 8'h01 << bsel;
  wire logic [9:0]        sum_wf = add8(f_val, w_val, 1'b0);
  wire logic [9:0]        sub_wf = add8(f_val, ~w_val, 1'b1);
  wire logic [9:0]        sum_wl = add8(lit, w_val, 1'b0);
  wire logic [9:0]        sub_wl = add8(lit, ~w_val, 1'b1);
  wire logic [9:0]        inc_f  = add8(f_val, 8'h01, 1'b0);
  wire logic [9:0]        dec_f  = add8(f_val, 8'hFF, 1'b0);

  // operation select; don't-care bits of literal ops are never decoded
  always_comb begin
    alu_out = '0;
    case (cls)
      CLS_BYTE: begin
        case (bop)
          BOP_MISC:  alu_out.result = w_val;
          BOP_CLR:   alu_out.result = 8'h00;
          BOP_SUB:   {alu_out.flags.c, alu_out.flags.dc, alu_out.result} = sub_wf;
          BOP_DEC:   alu_out.result = dec_f[7:0];
          BOP_IOR:   alu_out.result = w_val | f_val;
          BOP_AND:   alu_out.result = w_val & f_val;
          BOP_XOR:   alu_out.result = w_val ^ f_val;
          BOP_ADD:   {alu_out.flags.c, alu_out.flags.dc, alu_out.result} = sum_wf;
          BOP_MOV:   alu_out.result = f_val;
          BOP_COM:   alu_out.result = ~f_val;
          BOP_INC:   alu_out.result = inc_f[7:0];
          BOP_DECSZ: alu_out.result = dec_f[7:0];
          BOP_RR:    {alu_out.result, alu_out.flags.c} = {c_in, f_val};
          BOP_RL:    {alu_out.flags.c, alu_out.result} = {f_val, c_in};
          BOP_SWAP:  alu_out.result = {f_val[3:0], f_val[7:4]};
          default:   alu_out.result = inc_f[7:0];
        endcase
        alu_out.upd.c  = (bop == BOP_SUB) | (bop == BOP_ADD) | (bop == BOP_RR) |
                         (bop == BOP_RL);
        alu_out.upd.dc = (bop == BOP_SUB) | (bop == BOP_ADD);
        alu_out.upd.z  = ~(bop == BOP_MISC | bop == BOP_DECSZ | bop == BOP_RR |
                           bop == BOP_RL | bop == BOP_SWAP | bop == BOP_INCSZ);
        alu_out.skip   = (bop == BOP_DECSZ | bop == BOP_INCSZ) &
                         (alu_out.result == 8'h00);
      end
      CLS_BIT: begin
        alu_out.result = instr[10] ? (f_val | bmask) : (f_val & ~bmask);
        alu_out.skip   = instr[11] & (((f_val & bmask) != 8'h00) == instr[10]);
      end
      CLS_LIT: begin
        casez (bop)
          4'b00??, 4'b01??: alu_out.result = lit;
          4'b1000: alu_out.result = lit | w_val;
          4'b1001: alu_out.result = lit & w_val;
          4'b1010: alu_out.result = lit ^ w_val;
          4'b110?: {alu_out.flags.c, alu_out.flags.dc, alu_out.result} = sub_wl;
          default: {alu_out.flags.c, alu_out.flags.dc, alu_out.result} = sum_wl;
        endcase
        alu_out.upd.c  = bop[3] & bop[2];
        alu_out.upd.dc = bop[3] & bop[2];
        alu_out.upd.z  = bop[3];
      end
      default: alu_out.result = 8'h00;
    endcase
    alu_out.flags.z = (alu_out.result == 8'h00);
  end

endmodule

`default_nettype wire

// ==== design/mde_core.sv ====
/*
  Instruction decode and execute core: fetch, decode, file register
  read-modify-write, working register, status flags, call stack.
  Assumes program memory answers prog_addr within four clocks and the file
  register space answers a read combinationally in the same clock.
*/
`timescale 1ns/1ps
`default_nettype none

module mde_core
  import mde_pkg::*;
(
  // clock and reset
  input  wire logic               clk,
  input  wire logic               sys_rst,
  // program memory
  output logic [PC_W-1:0]         prog_addr,
  input  wire logic [INSTR_W-1:0] prog_data,
  input  wire logic [PAGE_W-1:0]  page_bits,
  // file register space
  output logic [FADDR_W-1:0]      file_addr,
  output logic                    file_rd_en,
  input  wire logic [DATA_W-1:0]  file_rd_data,
  output logic                    file_wr_en,
  output logic [DATA_W-1:0]       file_wr_data,
  // port pins and port change interrupt support
  input  wire logic [DATA_W-1:0]  port_pins,
  output logic                    port_read_clear,
  // core state
  output logic [DATA_W-1:0]       w_out,
  output mde_status_t             status,
  output mde_ctrl_t               ctrl
);

  // ***********************************************************
  // state
  // ***********************************************************
  mde_phase_t             phase_q;
  logic [PC_W-1:0]        pc_q;
  logic [INSTR_W-1:0]     instr_q;
  logic [FADDR_W-1:0]     faddr_q;
  logic                   flush_q;
  logic [DATA_W-1:0]      w_q;
  mde_status_t            status_q;
  logic [DATA_W-1:0]      fval_q;
  logic [DATA_W-1:0]      res_q;
  mde_alu_out_t           alu_q;
  mde_alu_out_t           alu_d;
  logic [PC_W-1:0]        stack_q [STACK_DEPTH];
  logic [SP_W-1:0]        sp_q;
  mde_ctrl_t              ctrl_q;
  logic [DATA_W-1:0]      pin_s1_q;
  logic [DATA_W-1:0]      pin_s2_q;
  logic [DATA_W-1:0]      pin_s3_q;
  logic [DATA_W-1:0]      pin_level_q;

  // ***********************************************************
  // decode
  // ***********************************************************
  // whole-word fields; the misc group is matched on its exact low byte and any other
  // misc pattern does nothing, so don't-care bits of the no-operation pattern have no effect
  wire logic [1:0] cls       = instr_q[CLASS_LSB+1:CLASS_LSB];
  wire logic [3:0] bop       = instr_q[BOP_LSB+3:BOP_LSB];
  wire logic       dest      = instr_q[DEST_BIT];
  wire logic       is_byte   = (cls == CLS_BYTE);
  wire logic       is_bit    = (cls == CLS_BIT);
  wire logic       is_jump   = (cls == CLS_JUMP);
  wire logic       is_lit    = (cls == CLS_LIT);
  wire logic       is_misc   = is_byte & (bop == BOP_MISC) & ~dest;
  wire logic       is_clrw   = is_byte & (bop == BOP_CLR) & ~dest;
  wire logic       is_ret    = is_misc & (instr_q[7:0] == MISC_RETURN);
  wire logic       is_retfie = is_misc & (instr_q[7:0] == MISC_RETFIE);
  wire logic       is_sleep  = is_misc & (instr_q[7:0] == MISC_SLEEP);
  wire logic       is_clrwdt = is_misc & (instr_q[7:0] == MISC_CLRWDT);
  wire logic       is_call   = is_jump & ~instr_q[JSEL_BIT];
  wire logic       is_retlw  = is_lit & (bop[3:2] == 2'b01);
  wire logic       exec_ok   = ~flush_q;

  // file read for every instruction that names a register, writers included
  wire logic       uses_file = (is_byte & ~is_misc & ~is_clrw) | is_bit;
  wire logic       wr_file   = (is_byte & dest) | (is_bit & ~instr_q[11]);
  wire logic       wr_w      = (is_byte & ~dest & ~is_misc) | is_lit;
  wire logic       pc_change = is_jump | is_retlw | is_ret | is_retfie;
  wire logic       two_cyc   = pc_change | alu_q.skip;
  wire logic       port_hit  = (faddr_q == PORT_ADDR);

  // next program counter: jump target, stack pop or sequential
  wire logic [PC_W-1:0] jump_tgt = {page_bits, instr_q[LIT_JUMP_W-1:0]};
  wire logic [SP_W-1:0] sp_dec   = sp_q - 3'h1;
  wire logic [PC_W-1:0] pc_inc   = pc_q + 13'h0001;
  wire logic [PC_W-1:0] pc_next  = ~exec_ok ? pc_inc :
                                   is_jump ? jump_tgt :
                                   (is_ret | is_retfie | is_retlw) ? stack_q[sp_dec] :
                                   pc_inc;

  // ***********************************************************
  // arithmetic unit
  // ***********************************************************
  mde_alu u_alu (
    .instr   (instr_q),
    .w_val   (w_q),
    .f_val   (fval_q),
    .c_in    (status_q.c),
    .alu_out (alu_d)
  );

  // ***********************************************************
  // phase sequencer
  // ***********************************************************
  // four clocks per instruction cycle; the clock is the oscillator
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      phase_q <= PH_Q1;
    end else begin
      case (phase_q)
        PH_Q1:   phase_q <= PH_Q2;
        PH_Q2:   phase_q <= PH_Q3;
        PH_Q3:   phase_q <= PH_Q4;
        PH_Q4:   phase_q <= PH_Q1;
        default: phase_q <= PH_Q1;
      endcase
    end
  end

  // ***********************************************************
  // pin synchroniser
  // ***********************************************************
  // a pin bit is taken only once the second and third stages agree
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pin_s1_q    <= 8'h00;
      pin_s2_q    <= 8'h00;
      pin_s3_q    <= 8'h00;
      pin_level_q <= 8'h00;
    end else begin
      pin_s1_q    <= port_pins;
      pin_s2_q    <= pin_s1_q;
      pin_s3_q    <= pin_s2_q;
      pin_level_q <= (pin_s2_q & ~(pin_s2_q ^ pin_s3_q)) |
                     (pin_level_q & (pin_s2_q ^ pin_s3_q));
    end
  end

  // ***********************************************************
  // read, modify
  // ***********************************************************
  // operand captured at end of Q2, result at end of Q3
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      fval_q <= 8'h00;
      res_q  <= 8'h00;
      alu_q  <= '0;
    end else begin
      if (phase_q == PH_Q2) begin
        fval_q <= port_hit ? pin_level_q : file_rd_data;
      end
      if (phase_q == PH_Q3) begin
        res_q <= alu_d.result;
        alu_q <= alu_d;
      end
    end
  end

  // ***********************************************************
  // write back and fetch
  // ***********************************************************
  // everything architectural changes at the end of Q4; a flushed cycle
  // only fetches, which is the trailing no-operation of a two-cycle op
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pc_q     <= PC_RESET;
      instr_q  <= '0;
      faddr_q  <= '0;
      flush_q  <= 1'b1;
      w_q      <= W_RESET;
      status_q <= '0;
      sp_q     <= SP_RESET;
      ctrl_q   <= '0;
    end else if (phase_q == PH_Q4) begin
      pc_q    <= pc_next;
      instr_q <= prog_data;
      faddr_q <= prog_data[FADDR_W-1:0];
      flush_q <= exec_ok & two_cyc;
      ctrl_q  <= {exec_ok, exec_ok & is_sleep, exec_ok & is_clrwdt,
                  exec_ok & is_retfie};
      if (exec_ok & wr_w) begin
        w_q <= res_q;
      end
      if (exec_ok) begin
        status_q.c  <= alu_q.upd.c ? alu_q.flags.c : status_q.c;
        status_q.dc <= alu_q.upd.dc ? alu_q.flags.dc : status_q.dc;
        status_q.z  <= alu_q.upd.z ? alu_q.flags.z : status_q.z;
      end
      if (exec_ok & is_call) begin
        sp_q <= sp_q + 3'h1;
      end else if (exec_ok & (is_ret | is_retfie | is_retlw)) begin
        sp_q <= sp_dec;
      end
    end else begin
      ctrl_q <= '0;
    end
  end

  // return stack, circular; the pushed value is the already advanced pc
  always_ff @(posedge clk) begin
    if ((phase_q == PH_Q4) & exec_ok & is_call) begin
      stack_q[sp_q] <= pc_q;
    end
  end

  // ***********************************************************
  // outputs
  // ***********************************************************
  // strobes are combinational from phase so the partner sees one clock
  assign file_rd_en      = (phase_q == PH_Q2) & exec_ok & uses_file;
  assign file_wr_en      = (phase_q == PH_Q4) & exec_ok & wr_file;
  assign port_read_clear = file_rd_en & port_hit;
  assign prog_addr       = pc_q;
  assign file_addr       = faddr_q;
  assign file_wr_data    = res_q;
  assign w_out           = w_q;
  assign status          = status_q;
  assign ctrl            = ctrl_q;

endmodule

`default_nettype wire

// ==== tb/mde_mem_model.sv ====
/*
  Behavioural program memory and file register space for the decode core.
  Assumes the bench loads rom and regs directly just before each run, one clock before it puts the core in reset.
*/
`timescale 1ns/1ps
`default_nettype none

module mde_mem_model
  import mde_pkg::*;
(
  // clock
  input  wire logic               clk,
  // program memory
  input  wire logic [PC_W-1:0]    prog_addr,
  output logic [INSTR_W-1:0]      prog_data,
  // file register space
  input  wire logic [FADDR_W-1:0] file_addr,
  input  wire logic               file_rd_en,
  output logic [DATA_W-1:0]       file_rd_data,
  input  wire logic               file_wr_en,
  input  wire logic [DATA_W-1:0]  file_wr_data
);
  // ***********************************************************
  // storage
  // ***********************************************************
  logic [INSTR_W-1:0] rom  [0:2047];
  logic [DATA_W-1:0]  regs [0:127];
  logic [DATA_W-1:0]  last_q;

  // empty memory reads as no_operation
  initial begin
    for (int i = 0; i < 2048; i++) rom[i] = 14'h0000;
    for (int i = 0; i < 128; i++) regs[i] = 8'h00;
    last_q = 8'h00;
  end

  // 11 address bits are enough for the test programs
  assign prog_data = rom[prog_addr[LIT_JUMP_W-1:0]];
  // idle read bus shows the inverse of the last read, so a late sample never matches by luck
  assign file_rd_data = file_rd_en ? regs[file_addr] : ~last_q;

  // write on the strobe edge; remember what was last read
  always @(posedge clk) begin
    if (file_rd_en) last_q <= regs[file_addr];
    if (file_wr_en) regs[file_addr] <= file_wr_data;
  end
endmodule

`default_nettype wire

// ==== tb/mde_core_chk.sv ====
/*
  Port-level checker of the decode and execute core.
  Assumes it is bound to mde_core and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none

module mde_core_chk
  import mde_pkg::*;
(
  // clock and reset
  input wire logic               clk,
  input wire logic               sys_rst,
  // watched ports
  input wire logic [PC_W-1:0]    prog_addr,
  input wire logic [FADDR_W-1:0] file_addr,
  input wire logic               file_rd_en,
  input wire logic               file_wr_en,
  input wire logic               port_read_clear,
  input wire logic [DATA_W-1:0]  w_out,
  input wire mde_ctrl_t          ctrl
);
  // ***********************************************************
  // timing of the instruction cycle
  // ***********************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_fetch_held: assert property ($changed(prog_addr) |=> $stable(prog_addr)[*3])
    else $error("program address changed inside an instruction cycle");
  a_done_spacing: assert property (ctrl.instr_done |=> (!ctrl.instr_done)[*3])
    else $error("instructions completed closer than four clocks");
  a_rd_then_done: assert property (file_rd_en |-> ##3 ctrl.instr_done)
    else $error("file read not followed by completion three clocks later");
  // a jump means the next cycle is quiet: no strobes, no completion
  a_branch_flush: assert property ($changed(prog_addr) &&
      (prog_addr - $past(prog_addr)) != 13'h0001
      |=> (!file_rd_en && !file_wr_en)[*3] ##1 !ctrl.instr_done)
    else $error("activity in the cycle after a jump");

  // ***********************************************************
  // read-modify-write
  // ***********************************************************
  a_read_before_write: assert property (file_wr_en |->
      $past(file_rd_en, 2) && $past(file_addr, 2) == file_addr)
    else $error("file write without a read of the same address");
  a_rd_single: assert property (file_rd_en |=> (!file_rd_en)[*3])
    else $error("more than one file read in a cycle");
  a_addr_held: assert property (file_rd_en |=> $stable(file_addr)[*2])
    else $error("file address moved between read and write");
  a_port_clear: assert property (port_read_clear ==
      (file_rd_en && file_addr == PORT_ADDR))
    else $error("port clear pulse does not match a port read");
  // a write to the port must come from a full read-modify-write, clear pulse included
  a_port_rmw_clear: assert property (file_wr_en && file_addr == PORT_ADDR |->
      $past(port_read_clear, 2))
    else $error("port rewritten without the read that clears its change flag");
  a_reset_clears: assert property ($fell(sys_rst) |->
      w_out == W_RESET && prog_addr == PC_RESET && ctrl == '0)
    else $error("core state not cleared by reset");

  // main scenarios
  c_write: cover property (file_wr_en);
  c_port: cover property (port_read_clear);
  c_jump: cover property ($changed(prog_addr) && (prog_addr - $past(prog_addr)) != 13'h0001);
endmodule

bind mde_core mde_core_chk chk (
  .clk             (clk),
  .sys_rst         (sys_rst),
  .prog_addr       (prog_addr),
  .file_addr       (file_addr),
  .file_rd_en      (file_rd_en),
  .file_wr_en      (file_wr_en),
  .port_read_clear (port_read_clear),
  .w_out           (w_out),
  .ctrl            (ctrl)
);

`default_nettype wire

// ==== tb/testbench.sv ====
/*
  Self-checking bench of the decode and execute core: small programs run
  from the memory model and the results are compared afterwards.
  Assumes mde_mem_model and the bound checker are compiled alongside.
*/
`timescale 1ns/1ps
`default_nettype none

module testbench;
  import mde_pkg::*;

  // ***********************************************************
  // signals
  // ***********************************************************
  logic                 clk;
  logic                 sys_rst;
  logic [PAGE_W-1:0]    page_bits;
  logic [DATA_W-1:0]    port_pins;
  logic [PC_W-1:0]      prog_addr;
  logic [INSTR_W-1:0]   prog_data;
  logic [FADDR_W-1:0]   file_addr;
  logic                 file_rd_en;
  logic [DATA_W-1:0]    file_rd_data;
  logic                 file_wr_en;
  logic [DATA_W-1:0]    file_wr_data;
  logic                 port_read_clear;
  logic [DATA_W-1:0]    w_out;
  mde_status_t          status;
  mde_ctrl_t            ctrl;
  int                   error_cnt = 0;
  int                   checks = 0;
  int                   cycle_cnt = 0;
  int                   clr_seen = 0;
  int                   done_cnt = 0;
  int                   sleep_cnt = 0;
  int                   wdt_cnt = 0;
  int                   ret_cnt = 0;

  mde_core dut (.clk(clk), .sys_rst(sys_rst), .prog_addr(prog_addr), .prog_data(prog_data),
    .page_bits(page_bits), .file_addr(file_addr), .file_rd_en(file_rd_en),
    .file_rd_data(file_rd_data), .file_wr_en(file_wr_en), .file_wr_data(file_wr_data),
    .port_pins(port_pins), .port_read_clear(port_read_clear), .w_out(w_out),
    .status(status), .ctrl(ctrl));
  mde_mem_model mem (.clk(clk), .prog_addr(prog_addr), .prog_data(prog_data),
    .file_addr(file_addr), .file_rd_en(file_rd_en), .file_rd_data(file_rd_data),
    .file_wr_en(file_wr_en), .file_wr_data(file_wr_data));

  // 200 MHz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // strobe and control pulses, counted outside reset so a stale program
  // cannot leak in; hang limit well above the ~260 cycles needed
  always @(posedge clk) begin
    cycle_cnt++;
    if (sys_rst === 1'b0) begin
      if (port_read_clear === 1'b1) clr_seen++;
      if (ctrl.instr_done === 1'b1) done_cnt++;
      if (ctrl.sleep_req === 1'b1) sleep_cnt++;
      if (ctrl.wdt_clear === 1'b1) wdt_cnt++;
      if (ctrl.int_return === 1'b1) ret_cnt++;
    end
    if (cycle_cnt == 1000) begin
      error_cnt++;
      complete_run();
    end
  end

  // ***********************************************************
  // helpers
  // ***********************************************************
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic [13:0] bop(input logic [3:0] op, input logic d, input logic [6:0] f);
    return {2'b00, op, d, f};
  endfunction

  function automatic logic [13:0] bitop(input logic [1:0] op, input logic [2:0] b,
                                        input logic [6:0] f);
    return {2'b01, op, b, f};
  endfunction

  // reset for six clocks, then let n instruction cycles run
  task automatic run(input int n);
    @(posedge clk);
    #1 sys_rst = 1'b1;
    clr_seen = 0;
    done_cnt = 0;
    sleep_cnt = 0;
    wdt_cnt = 0;
    ret_cnt = 0;
    repeat (6) @(posedge clk);
    #1 sys_rst = 1'b0;
    repeat (4 * n) @(posedge clk);
    #1;
  endtask

  // ***********************************************************
  // scenarios
  // ***********************************************************
  task automatic test_byte_ops();
    mem.regs[7'h20] = 8'h05;
    mem.rom[0] = {6'b110011, 8'h3C};   // literal move with don't-care bits set
    mem.rom[1] = bop(BOP_MISC, 1'b1, 7'h7F);
    mem.rom[2] = bop(BOP_ADD, 1'b0, 7'h20);
    mem.rom[3] = bop(BOP_ADD, 1'b1, 7'h20);
    mem.rom[4] = {3'b101, 11'h004};
    run(8);
    check(mem.regs[7'h7F], 8'h3C);
    check(w_out, 8'h41);
    check(mem.regs[7'h20], 8'h46);
    check({5'h00, status}, 8'h00);
    $display("test byte ops done");
  endtask

  // set every bit position in turn, then clear one
  task automatic test_bit_ops();
    for (int b = 0; b < 8; b++) mem.rom[b] = bitop(2'b01, 3'(b), 7'h10);
    mem.rom[8] = bitop(2'b00, 3'h3, 7'h10);
    mem.rom[9] = {3'b101, 11'h009};
    run(12);
    check(mem.regs[7'h10], 8'hF7);
    $display("test bit ops done");
  endtask

  // far jump, taken skip; the 0xEE loads must never execute
  task automatic test_flow();
    mem.regs[7'h11] = 8'h00;
    mem.rom[0] = {6'b110000, 8'h01};
    mem.rom[1] = {3'b101, 11'h7FC};
    mem.rom[2] = {6'b110000, 8'hEE};
    mem.rom[11'h7FC] = bitop(2'b10, 3'h0, 7'h11);
    mem.rom[11'h7FD] = {6'b110000, 8'hEE};
    mem.rom[11'h7FE] = {6'b110000, 8'h55};
    mem.rom[11'h7FF] = {3'b101, 11'h7FF};
    run(12);
    check(prog_addr[7:0], 8'hFF);
    check(w_out, 8'h55);
    $display("test flow done");
  endtask

  // pins differ from the stored latch value
  task automatic test_port();
    mem.regs[PORT_ADDR] = 8'h3C;
    port_pins = 8'hA5;
    mem.rom[0] = bop(BOP_MOV, 1'b0, PORT_ADDR);
    mem.rom[1] = bop(BOP_CLR, 1'b1, PORT_ADDR);
    mem.rom[2] = {3'b101, 11'h002};
    run(6);
    check(w_out, 8'hA5);
    check(mem.regs[PORT_ADDR], 8'h00);
    check(8'(clr_seen), 8'h02);
    check({5'h00, status}, 8'h01);
    $display("test port done");
  endtask

  // nested calls and all three returns, then the control codes; every
  // program counter change must cost one extra, quiet cycle
  task automatic test_calls();
    mem.rom[0] = {3'b100, 11'h010};
    mem.rom[1] = bop(BOP_MISC, 1'b1, 7'h30);
    mem.rom[2] = {6'b000000, MISC_SLEEP};
    mem.rom[3] = {6'b000000, MISC_CLRWDT};
    mem.rom[4] = {3'b101, 11'h004};
    mem.rom[11'h010] = {3'b100, 11'h018};
    mem.rom[11'h011] = {6'b110100, 8'h5A};
    mem.rom[11'h018] = {3'b100, 11'h01C};
    mem.rom[11'h019] = {6'b000000, MISC_RETFIE};
    mem.rom[11'h01C] = {6'b000000, MISC_RETURN};
    run(18);
    check(mem.regs[7'h30], 8'h5A);
    check(w_out, 8'h5A);
    check(8'(done_cnt), 8'h0A);
    check(8'(sleep_cnt), 8'h01);
    check(8'(wdt_cnt), 8'h01);
    check(8'(ret_cnt), 8'h01);
    $display("test calls done");
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // main sequence
  initial begin
    sys_rst = 1'b1;
    page_bits = 2'h0;
    port_pins = 8'h00;
    test_byte_ops();
    test_bit_ops();
    test_flow();
    test_port();
    test_calls();
    complete_run();
  end
endmodule

`default_nettype wire
